// ---- dbm_pkg.sv ----
// Purpose: shared constants and types of the debug module register bank
// Assumes: 18-bit global debug-space addresses, 8-bit register data
// Notes: every offset, field position, reset value and count is named once here
package dbm_pkg;

    // global addresses of the debug space
    localparam logic [17:0] ADDR_REG_LO = 18'h3_ff00;
    localparam logic [17:0] ADDR_STATUS = 18'h3_ff01;
    localparam logic [17:0] ADDR_CCR_HOLD = 18'h3_ff06;
    localparam logic [17:0] ADDR_PAGE = 18'h3_ff08;
    localparam logic [17:0] ADDR_REG_HI = 18'h3_ff0b;
    localparam logic [17:0] ADDR_FAMILY = 18'h3_ff0f;

    // debug_status field positions
    localparam int STS_ENABLE_BIT = 7;
    localparam int STS_ACTIVE_BIT = 6;
    localparam int STS_SDONE_BIT = 4;
    localparam int STS_STEP_BIT = 3;
    localparam int STS_UNSECURE_FLAG_BIT = 1;

    // program_page_index field positions
    localparam int PAGE_ENABLE_BIT = 7;
    localparam int PAGE_SEL_MSB = 3;
    localparam int PAGE_SEL_LSB = 0;

    // reset values
    localparam logic [7:0] CCR_RST_SPECIAL = 8'hd8;
    localparam logic [7:0] CCR_RST_OTHER = 8'h00;
    localparam logic [3:0] PAGE_SEL_RST = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // refused activation costs the processor a short stall
    localparam int REFUSE_DELAY_NS = 100;
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [2:0] REFUSE_CYCLES = 3'((REFUSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // originator of a debug-space access
    localparam logic [1:0] SRC_HW_CMD = 2'h0;
    localparam logic [1:0] SRC_FW_STD = 2'h1;
    localparam logic [1:0] SRC_FW_SEC = 2'h2;
    localparam logic [1:0] SRC_USER = 2'h3;

    typedef enum logic [2:0] {
        SEC_OPEN = 3'b001,
        SEC_VERIFY = 3'b010,
        SEC_LOCKED = 3'b100
    } dbm_sec_e;

    typedef enum logic [1:0] {
        ENT_IDLE = 2'b01,
        ENT_STALL = 2'b10
    } dbm_ent_e;

endpackage : dbm_pkg

// ---- dbm_entry_ctl.sv ----
// Purpose: decides whether an activation request enters debug mode
// Assumes: request is a one-cycle pulse on i_clk
// Notes: a refused request stalls briefly and then reports refusal
`timescale 1ns/1ns
module dbm_entry_ctl
    import dbm_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_reset, // synchronous reset, high
    input wire logic i_req, // activation request pulse
    input wire logic i_enable, // debug enable flag
    input wire logic i_active, // debug already active
    output logic o_enter, // enter debug mode, pulse
    output logic o_refused // request refused, pulse after stall
);

    typedef struct packed {
        dbm_ent_e st;
        logic [2:0] cnt;
        logic enter;
        logic refused;
    } dbm_ent_s;

    dbm_ent_s st_r;
    dbm_ent_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.enter = 1'b0;
        st_nxt.refused = 1'b0;
        case (st_r.st)
            ENT_IDLE: begin
                if (i_req && !i_active) begin
                    if (i_enable) begin
                        st_nxt.enter = 1'b1;
                    end else begin
                        st_nxt.st = ENT_STALL;
                        st_nxt.cnt = REFUSE_CYCLES;
                    end
                end
            end
            ENT_STALL: begin
                st_nxt.cnt = st_r.cnt - 3'h1;
                if (st_r.cnt == 3'h1) begin
                    st_nxt.st = ENT_IDLE;
                    st_nxt.refused = 1'b1;
                end
            end
            default: begin
                st_nxt.st = ENT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_r <= '{st: ENT_IDLE, cnt: 3'h0, enter: 1'b0, refused: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_enter = st_r.enter;
    assign o_refused = st_r.refused;

endmodule : dbm_entry_ctl

// ---- dbm_reg_bank.sv ----
// Purpose: debug module register bank (status, condition-code holding, page index, family_identifier)
// Assumes: debug-space commands arrive already decoded on one access port
// Notes: all inputs come from logic on i_clk; no synchronisers needed
//
// Overview of operation
// - enable flag gates activation, memory commands unaffected
// - enable set at special reset unless secured
// - active set by entry, cleared by firmware store
// - active maps firmware table; clearing returns user
// - shift-done set after data, cleared next command
// - single-step flag held until resume command
// - unsecure zero at secure entry; secure firmware writes
// - erase pass sets unsecure, drops secure table
// - unsecure set lets flash security bits change
// - registers accessible only via debug, unsecured
// - entry copies processor condition codes into holding
// - holding resets D8 special, zero otherwise
// - holding write changes resumed condition codes
// - page access enable applies paging to accesses
// - debug-space commands never paged or global
// - page select bits choose program page
// - family identifier readable while debug active
// - register window hidden from user programs
// - registers serviced through debug-space read/write commands
`timescale 1ns/1ns
module dbm_reg_bank
    import dbm_pkg::*;
#(
    parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5a // arbitrary value
)(
    input wire logic i_clk, // system clock, 20 MHz
    input wire logic i_reset, // synchronous reset, high
    input wire logic i_special_sc, // special single chip mode
    input wire logic i_secured, // flash security set to secured
    input wire logic i_erase_done, // erase verify finished, pulse
    input wire logic i_erase_pass, // erase verify result with done
    input wire logic i_acc_rd, // debug-space read strobe
    input wire logic i_acc_wr, // debug-space write strobe
    input wire logic [1:0] i_acc_src, // originator of access
    input wire logic [17:0] i_acc_addr, // global address
    input wire logic [7:0] i_acc_wdata, // write data
    input wire logic i_enter_req, // activation request pulse
    input wire logic [7:0] i_cpu_ccr, // processor condition codes
    input wire logic i_cmd_received, // new command received, pulse
    input wire logic i_data_phase_done, // data phase finished, pulse
    input wire logic i_single_step_cmd, // single-step recognised, pulse
    input wire logic i_resume_cmd, // resume or resume-until, pulse
    input wire logic i_bd_space, // current command is debug-space
    output logic [7:0] o_rdata, // read data, registered
    output logic o_rvalid, // read data valid, pulse
    output logic o_debug_enable, // debug enable flag
    output logic o_debug_active, // debug active flag
    output logic o_fw_table_mapped, // standard firmware table in map
    output logic o_secure_table_mapped, // secure firmware table in map
    output logic o_return_to_user, // exit to user code, pulse
    output logic o_enter_refused, // activation refused, pulse
    output logic [7:0] o_resume_ccr, // condition codes to resume with
    output logic o_paged_access, // apply paging to this access
    output logic [3:0] o_page_select, // selected program page
    output logic o_flash_sec_changeable // flash security may change
);

    typedef struct packed {
        dbm_sec_e sec;
        logic enable;
        logic active;
        logic sdone;
        logic step;
        logic unsecure_flag;
        logic [7:0] condition_code_register;
        logic page_en;
        logic [3:0] page_sel;
        logic [7:0] rdata;
        logic rvalid;
        logic exit_pulse;
    } dbm_state_s;

    dbm_state_s st_r;
    dbm_state_s st_nxt;
    dbm_state_s st_rst;
    logic enter;
    logic locked;
    logic allowed;
    logic wr_ok;

    function automatic logic hit(input logic [17:0] addr, input logic [17:0] target);
        hit = (addr == target);
    endfunction : hit

    dbm_entry_ctl u_entry (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_req(i_enter_req),
        .i_enable(st_r.enable),
        .i_active(st_r.active),
        .o_enter(enter),
        .o_refused(o_enter_refused)
    );

    // device counts as secured until the unsecure flag is set
    assign locked = i_secured && !st_r.unsecure_flag;
    assign allowed = (i_acc_src != SRC_USER) && !locked;
    assign wr_ok = i_acc_wr && allowed;

    always_comb begin
        st_rst = '0;
        st_rst.enable = i_special_sc && !i_secured;
        st_rst.active = i_special_sc && !i_secured;
        st_rst.unsecure_flag = 1'b0;
        st_rst.condition_code_register = i_special_sc ? CCR_RST_SPECIAL : CCR_RST_OTHER;
        st_rst.page_sel = PAGE_SEL_RST;
        if (!i_secured) begin
            st_rst.sec = SEC_OPEN;
        end else if (i_special_sc) begin
            st_rst.sec = SEC_VERIFY;
        end else begin
            st_rst.sec = SEC_LOCKED;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.exit_pulse = 1'b0;

        // clears first so that a hardware set in the same cycle wins
        if (i_cmd_received) begin
            st_nxt.sdone = 1'b0;
        end
        if (i_resume_cmd) begin
            st_nxt.step = 1'b0;
        end

        if (wr_ok && hit(i_acc_addr, ADDR_STATUS)) begin
            st_nxt.enable = i_acc_wdata[STS_ENABLE_BIT];
            st_nxt.sdone = i_acc_wdata[STS_SDONE_BIT];
            st_nxt.step = i_acc_wdata[STS_STEP_BIT];
            st_nxt.unsecure_flag = i_acc_wdata[STS_UNSECURE_FLAG_BIT];
            if (i_acc_src == SRC_FW_STD && !i_acc_wdata[STS_ACTIVE_BIT]) begin
                st_nxt.active = 1'b0;
            end
        end
        if (i_acc_wr && locked && i_special_sc && i_acc_src == SRC_FW_SEC
            && hit(i_acc_addr, ADDR_STATUS)) begin
            st_nxt.unsecure_flag = i_acc_wdata[STS_UNSECURE_FLAG_BIT];
            st_nxt.enable = i_acc_wdata[STS_ENABLE_BIT];
        end
        if (wr_ok && hit(i_acc_addr, ADDR_CCR_HOLD)) begin
            st_nxt.condition_code_register = i_acc_wdata;
        end
        if (wr_ok && hit(i_acc_addr, ADDR_PAGE)) begin
            st_nxt.page_en = i_acc_wdata[PAGE_ENABLE_BIT];
            st_nxt.page_sel = i_acc_wdata[PAGE_SEL_MSB:PAGE_SEL_LSB];
        end

        if (i_data_phase_done) begin
            st_nxt.sdone = 1'b1;
        end
        if (i_single_step_cmd) begin
            st_nxt.step = 1'b1;
        end

        // entry beats a concurrent write to the holding register
        if (enter) begin
            st_nxt.active = 1'b1;
            st_nxt.condition_code_register = i_cpu_ccr;
        end

        if (st_r.active && !st_nxt.active) begin
            st_nxt.exit_pulse = 1'b1;
            st_nxt.sdone = 1'b0;
        end

        case (st_r.sec)
            SEC_OPEN: begin
                st_nxt.sec = SEC_OPEN;
            end
            SEC_VERIFY: begin
                if (i_erase_done) begin
                    st_nxt.enable = 1'b1;
                    if (i_erase_pass) begin
                        st_nxt.unsecure_flag = 1'b1;
                        st_nxt.sec = SEC_OPEN;
                    end else begin
                        st_nxt.unsecure_flag = 1'b0;
                        st_nxt.sec = SEC_LOCKED;
                    end
                end
            end
            SEC_LOCKED: begin
                // firmware loops; only a secure firmware store of the unsecure flag leaves this state
                if (st_nxt.unsecure_flag) begin
                    st_nxt.sec = SEC_OPEN;
                end
            end
            default: begin
                st_nxt.sec = SEC_LOCKED;
            end
        endcase

        if (i_acc_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = READ_ZERO;
            if (allowed) begin
                if (hit(i_acc_addr, ADDR_STATUS)) begin
                    st_nxt.rdata[STS_ENABLE_BIT] = st_r.enable;
                    st_nxt.rdata[STS_ACTIVE_BIT] = st_r.active;
                    st_nxt.rdata[STS_SDONE_BIT] = st_r.sdone;
                    st_nxt.rdata[STS_STEP_BIT] = st_r.step;
                    st_nxt.rdata[STS_UNSECURE_FLAG_BIT] = st_r.unsecure_flag;
                end else if (hit(i_acc_addr, ADDR_CCR_HOLD)) begin
                    st_nxt.rdata = st_r.condition_code_register;
                end else if (hit(i_acc_addr, ADDR_PAGE)) begin
                    st_nxt.rdata[PAGE_ENABLE_BIT] = st_r.page_en;
                    st_nxt.rdata[PAGE_SEL_MSB:PAGE_SEL_LSB] = st_r.page_sel;
                end else if (hit(i_acc_addr, ADDR_FAMILY) && st_r.active) begin
                    st_nxt.rdata = FAMILY_IDENTIFIER;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_r <= st_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_rvalid = st_r.rvalid;
    assign o_debug_enable = st_r.enable;
    assign o_debug_active = st_r.active;
    assign o_fw_table_mapped = st_r.active;
    assign o_secure_table_mapped = (st_r.sec == SEC_VERIFY);
    assign o_return_to_user = st_r.exit_pulse;
    assign o_resume_ccr = st_r.condition_code_register;
    // debug-space commands bypass paging whatever the enable says
    assign o_paged_access = st_r.page_en && !i_bd_space;
    assign o_page_select = st_r.page_sel;
    // meaningless once the flash itself is configured unsecure
    assign o_flash_sec_changeable = st_r.unsecure_flag && i_secured;

    // helper: cycle after reset release
    logic post_rst_r;
    logic post_special_r;
    logic post_secured_r;

    always_ff @(posedge i_clk) begin
        post_rst_r <= i_reset;
        post_special_r <= i_special_sc;
        post_secured_r <= i_secured;
    end

    AST_RESET_ENABLE: assert property (@(posedge i_clk) disable iff (i_reset)
        post_rst_r |-> (o_debug_enable == (post_special_r && !post_secured_r)))
        else $error("enable flag wrong after reset");

    AST_RESET_CCR: assert property (@(posedge i_clk) disable iff (i_reset)
        post_rst_r |-> (o_resume_ccr == (post_special_r ? CCR_RST_SPECIAL : CCR_RST_OTHER)))
        else $error("holding register wrong after reset");

    AST_REFUSED_STAYS_IDLE: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_enter_req && !o_debug_enable && !o_debug_active) |=> !o_debug_active [*3])
        else $error("activation not refused while disabled");

    AST_ACTIVE_SET_BY_ENTRY: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_debug_active) |-> $past(enter))
        else $error("active flag set without entry");

    AST_ACTIVE_CLR_BY_FW: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(o_debug_active) |-> $past(i_acc_wr) && ($past(i_acc_src) == SRC_FW_STD) && o_return_to_user)
        else $error("active flag cleared without firmware store");

    AST_SDONE_SET: assert property (@(posedge i_clk) disable iff (i_reset)
        i_data_phase_done |=> st_r.sdone || $fell(o_debug_active))
        else $error("shift-done not set after data phase");

    AST_SDONE_CLR: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_cmd_received && !i_data_phase_done && !i_acc_wr) |=> !st_r.sdone)
        else $error("shift-done not cleared on new command");

    AST_STEP_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        (st_r.step && !i_resume_cmd && !i_acc_wr) |=> st_r.step)
        else $error("single-step flag dropped before resume");

    AST_CCR_CAPTURE: assert property (@(posedge i_clk) disable iff (i_reset)
        enter |=> (o_resume_ccr == $past(i_cpu_ccr)) && o_debug_active)
        else $error("condition codes not captured on entry");

    AST_SECURED_READ_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_acc_rd && i_secured && !st_r.unsecure_flag) |=> (o_rvalid && o_rdata == READ_ZERO))
        else $error("secured read returned data");

    AST_USER_READ_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_acc_rd && i_acc_src == SRC_USER) |=> (o_rdata == READ_ZERO))
        else $error("user program read debug register");

    AST_BD_NOT_PAGED: assert property (@(posedge i_clk) disable iff (i_reset)
        i_bd_space |-> !o_paged_access)
        else $error("debug-space command paged");

    AST_ERASE_PASS: assert property (@(posedge i_clk) disable iff (i_reset)
        (st_r.sec == SEC_VERIFY && i_erase_done && i_erase_pass)
        |=> (st_r.unsecure_flag && o_debug_enable && !o_secure_table_mapped))
        else $error("erase pass did not unsecure");

    AST_ERASE_FAIL: assert property (@(posedge i_clk) disable iff (i_reset)
        (st_r.sec == SEC_VERIFY && i_erase_done && !i_erase_pass && !i_acc_wr)
        |=> (!st_r.unsecure_flag && o_debug_enable))
        else $error("erase fail left unsecure set");

    AST_FAMILY_READ: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_acc_rd && allowed && o_debug_active && i_acc_addr == ADDR_FAMILY) |=> (o_rdata == FAMILY_IDENTIFIER))
        else $error("family identifier not returned");

    AST_EXIT_CLEARS_SDONE: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(o_debug_active) |-> !st_r.sdone)
        else $error("shift-done kept after exit");

    AST_PAGE_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_ok && hit(i_acc_addr, ADDR_PAGE)) |=> (o_page_select == 4'($past(i_acc_wdata))))
        else $error("page select not written");

    AST_LOCKED_WRITE_IGNORED: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_acc_wr && locked && i_acc_src == SRC_HW_CMD && !i_erase_done) |=> $stable(st_r.unsecure_flag))
        else $error("secured write changed unsecure flag");

    CV_ENTRY: cover property (@(posedge i_clk) disable iff (i_reset)
        enter ##1 o_debug_active);

    CV_EXIT: cover property (@(posedge i_clk) disable iff (i_reset)
        o_debug_active ##1 o_return_to_user);

    CV_REFUSED: cover property (@(posedge i_clk) disable iff (i_reset)
        o_enter_refused);

    CV_UNSECURE: cover property (@(posedge i_clk) disable iff (i_reset)
        $rose(st_r.unsecure_flag) && o_secure_table_mapped == 1'b0);

    CV_SECURE_FW_UNLOCK: cover property (@(posedge i_clk) disable iff (i_reset)
        st_r.sec == SEC_LOCKED ##1 st_r.sec == SEC_OPEN);

endmodule : dbm_reg_bank

// ---- dbm_reg_bank_note_placeholder.sv ----
`timescale 1ns/1ns

// ---- dbm_host_model.sv ----
// Purpose: debug host model issuing debug-space register accesses
// Assumes: one access per call, strobe held for one taking edge
// Notes: released address and data lines show inverted values
`timescale 1ns/1ns
module dbm_host_model (
    input wire logic i_clk, // system clock
    output logic o_acc_rd, // read strobe
    output logic o_acc_wr, // write strobe
    output logic [1:0] o_acc_src, // originator
    output logic [17:0] o_acc_addr, // global address
    output logic [7:0] o_acc_wdata // write data
);
    initial begin
        o_acc_rd = 1'h0;
        o_acc_wr = 1'h0;
        o_acc_src = 2'h0;
        o_acc_addr = 18'h0_0000;
        o_acc_wdata = 8'h00;
    end

    // registers are reached only through debug-space commands
    task automatic access(input logic rd, input logic [1:0] src, input logic [17:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_acc_rd <= rd;
        o_acc_wr <= !rd;
        o_acc_src <= src;
        o_acc_addr <= addr;
        o_acc_wdata <= data;
        @(posedge i_clk);
        o_acc_rd <= 1'h0;
        o_acc_wr <= 1'h0;
        // stale lines must never look like a valid access
        o_acc_addr <= ~addr;
        o_acc_wdata <= ~data;
    endtask : access
endmodule : dbm_host_model

// ---- tb.sv ----
// Purpose: self-checking bench of the debug register bank
// Assumes: integer model predicts every read answer
// Notes: event inputs are packed in one vector of pulses
`timescale 1ns/1ns
module tb
    import dbm_pkg::*;
;
    localparam logic [7:0] FAM = 8'h3c; // arbitrary value
    localparam logic [6:0] EV_ERASE = 7'h01, EV_ENTER = 7'h02, EV_CMD = 7'h04, EV_DATA = 7'h08;
    localparam logic [6:0] EV_STEP = 7'h10, EV_RESUME = 7'h20, EV_PASS = 7'h40;
    logic i_clk, i_reset, i_special_sc, i_secured, i_bd_space, i_acc_rd, i_acc_wr;
    logic [1:0] i_acc_src;
    logic [17:0] i_acc_addr;
    logic [7:0] i_acc_wdata, i_cpu_ccr, o_rdata, o_resume_ccr, d;
    logic [6:0] ev;
    logic o_rvalid, o_debug_enable, o_debug_active, o_fw_table_mapped, o_secure_table_mapped;
    logic o_return_to_user, o_enter_refused, o_paged_access, o_flash_sec_changeable;
    logic [3:0] o_page_select;
    int miscompares, checks_done, seed, n;
    int m_en, m_act, m_sd, m_st, m_un, m_ccr, m_pg, m_sec;
    int exp_q[$];

    dbm_host_model host (.i_clk, .o_acc_rd(i_acc_rd), .o_acc_wr(i_acc_wr), .o_acc_src(i_acc_src),
        .o_acc_addr(i_acc_addr), .o_acc_wdata(i_acc_wdata));
    dbm_reg_bank #(.FAMILY_IDENTIFIER(FAM)) DUT (.i_clk, .i_reset, .i_special_sc, .i_secured,
        .i_erase_done(ev[0]), .i_erase_pass(ev[6]), .i_acc_rd, .i_acc_wr, .i_acc_src, .i_acc_addr,
        .i_acc_wdata, .i_enter_req(ev[1]), .i_cpu_ccr, .i_cmd_received(ev[2]), .i_data_phase_done(ev[3]),
        .i_single_step_cmd(ev[4]), .i_resume_cmd(ev[5]), .i_bd_space, .o_rdata, .o_rvalid, .o_debug_enable,
        .o_debug_active, .o_fw_table_mapped, .o_secure_table_mapped, .o_return_to_user, .o_enter_refused,
        .o_resume_ccr, .o_paged_access, .o_page_select, .o_flash_sec_changeable);

    initial begin
        i_clk = 1'h0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic int model_rd(input logic [17:0] a, input logic [1:0] s);
        if (s == SRC_USER || (m_sec != 0 && m_un == 0)) return 0;
        case (a)
            ADDR_STATUS: return m_en * 128 + m_act * 64 + m_sd * 16 + m_st * 8 + m_un * 2;
            ADDR_CCR_HOLD: return m_ccr;
            ADDR_PAGE: return m_pg;
            ADDR_FAMILY: return m_act != 0 ? int'(FAM) : 0;
            default: return 0;
        endcase
    endfunction : model_rd

    task automatic rd(input logic [17:0] a, input logic [1:0] s);
        exp_q.push_back(model_rd(a, s));
        host.access(1'h1, s, a, 8'h00);
    endtask : rd

    task automatic wr(input logic [17:0] a, input logic [1:0] s, input logic [7:0] v);
        host.access(1'h0, s, a, v);
        if (a == ADDR_CCR_HOLD) m_ccr = v;
        if (a == ADDR_PAGE) m_pg = v & 8'h8f;
    endtask : wr

    task automatic wait_edge;
        @(posedge i_clk);
        #1;
    endtask : wait_edge

    task automatic pulse(input logic [6:0] m);
        @(posedge i_clk);
        ev <= m;
        @(posedge i_clk);
        ev <= 7'h00;
        #1;
    endtask : pulse

    task automatic do_reset(input logic sp, input logic se);
        @(posedge i_clk);
        i_reset <= 1'h1;
        i_special_sc <= sp;
        i_secured <= se;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'h0;
        exp_q.delete();
        m_en = sp && !se;
        m_act = m_en;
        {m_sd, m_st, m_un, m_pg} = '0;
        m_ccr = sp ? CCR_RST_SPECIAL : CCR_RST_OTHER;
        m_sec = se;
        #1;
    endtask : do_reset

    // every answer of a read is held against the model
    always @(posedge i_clk) begin
        if (o_rvalid === 1'h1) begin
            if (exp_q.size() == 0) check(1'h1, 1'h0);
            else check(o_rdata, exp_q.pop_front());
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    initial begin
        {miscompares, checks_done} = '0;
        seed = 32'h6955;
        {i_reset, i_special_sc, i_secured, i_bd_space, ev, i_cpu_ccr} = '1;
        i_bd_space = 1'h0;
        ev = 7'h00;
        do_reset(1'h1, 1'h0);
        check(o_debug_enable, 1'h1);
        check(o_fw_table_mapped, 1'h1);
        rd(ADDR_STATUS, SRC_HW_CMD);
        rd(ADDR_CCR_HOLD, SRC_HW_CMD);
        rd(ADDR_FAMILY, SRC_HW_CMD);
        rd(ADDR_REG_HI, SRC_HW_CMD);
        rd(ADDR_STATUS, SRC_USER);
        $display("test special reset done");
        d = 8'($random(seed));
        wr(ADDR_CCR_HOLD, SRC_FW_STD, d);
        wait_edge;
        check(o_resume_ccr, m_ccr);
        rd(ADDR_CCR_HOLD, SRC_HW_CMD);
        wr(ADDR_PAGE, SRC_HW_CMD, d | 8'h80);
        wait_edge;
        check(o_page_select, m_pg[3:0]);
        check(o_paged_access, 1'h1);
        @(posedge i_clk);
        i_bd_space <= 1'h1;
        #1;
        check(o_paged_access, 1'h0);
        rd(ADDR_PAGE, SRC_HW_CMD);
        i_bd_space <= 1'h0;
        wr(ADDR_PAGE, SRC_HW_CMD, d & 8'h7f);
        wait_edge;
        check(o_paged_access, 1'h0);
        $display("test holding and page done");
        pulse(EV_DATA);
        m_sd = 1;
        rd(ADDR_STATUS, SRC_HW_CMD);
        pulse(EV_CMD);
        m_sd = 0;
        rd(ADDR_STATUS, SRC_HW_CMD);
        pulse(EV_STEP);
        m_st = 1;
        rd(ADDR_STATUS, SRC_HW_CMD);
        pulse(EV_RESUME);
        m_st = 0;
        rd(ADDR_STATUS, SRC_HW_CMD);
        $display("test status events done");
        // host store without active bit must not end the session; host store loads enable, shift-done, step and unsecure bits, never active
        wr(ADDR_STATUS, SRC_HW_CMD, 8'h80);
        wait_edge;
        check(o_debug_active, 1'h1);
        wr(ADDR_STATUS, SRC_FW_STD, 8'h80);
        #1;
        check(o_return_to_user, 1'h1);
        check(o_fw_table_mapped, 1'h0);
        m_act = 0;
        rd(ADDR_FAMILY, SRC_HW_CMD);
        @(posedge i_clk);
        i_cpu_ccr <= 8'($random(seed));
        pulse(EV_ENTER);
        wait_edge;
        check(o_debug_active, 1'h1);
        check(o_resume_ccr, i_cpu_ccr);
        m_act = 1;
        m_ccr = i_cpu_ccr;
        rd(ADDR_CCR_HOLD, SRC_HW_CMD);
        $display("test exit and entry done");
        wr(ADDR_STATUS, SRC_FW_STD, 8'h80);
        // enable dropped by a hardware command while firmware is not needed
        wr(ADDR_STATUS, SRC_HW_CMD, 8'h00);
        {m_act, m_en} = '0;
        pulse(EV_ENTER);
        for (n = 0; n < 8 && o_enter_refused !== 1'h1; n++) wait_edge;
        check(n < 8, 1'h1);
        check(o_debug_active, 1'h0);
        rd(ADDR_CCR_HOLD, SRC_HW_CMD);
        $display("test refused entry done");
        do_reset(1'h0, 1'h0);
        check(o_debug_enable, 1'h0);
        rd(ADDR_CCR_HOLD, SRC_HW_CMD);
        do_reset(1'h1, 1'h1);
        check(o_debug_enable, 1'h0);
        check(o_secure_table_mapped, 1'h1);
        rd(ADDR_STATUS, SRC_HW_CMD);
        pulse(EV_ERASE | EV_PASS);
        check(o_debug_enable, 1'h1);
        check(o_secure_table_mapped, 1'h0);
        check(o_flash_sec_changeable, 1'h1);
        {m_en, m_un} = {32'h1, 32'h1};
        rd(ADDR_STATUS, SRC_HW_CMD);
        do_reset(1'h1, 1'h1);
        pulse(EV_ERASE);
        check(o_debug_enable, 1'h1);
        check(o_flash_sec_changeable, 1'h0);
        m_en = 1;
        rd(ADDR_STATUS, SRC_HW_CMD);
        // while locked only secure firmware may touch the unsecure flag
        wr(ADDR_STATUS, SRC_HW_CMD, 8'h02);
        rd(ADDR_STATUS, SRC_HW_CMD);
        wr(ADDR_STATUS, SRC_FW_SEC, 8'h82);
        m_un = 1;
        rd(ADDR_STATUS, SRC_HW_CMD);
        $display("test security done");
        repeat (3) wait_edge;
        check(exp_q.size(), 1'h0);
        close_out;
    end
endmodule : tb
